// *** hdl/qbsdr_array.sv ***
/*
  single-data-rate sdram array: four banks of rows x columns x 32-bit words,
  command decode, burst engine, auto precharge, read latency pipeline, byte masks.
  assumes the controller runs on sys_clk, keeps row and refresh timing, and
  that the data pin is resolved outside from dq_out and dq_oe.
*/
`timescale 1ns/10ps

// What this block does
// - all commands, addresses, masks and write data sampled on rising sys_clk edge
// - ACTIVE: two bank bits pick the bank, twelve address bits pick the row
// - READ or WRITE: low eight address bits give the first burst column
// - four banks of 4096 rows by 256 columns, each column a 32-bit word
// - bursts of 1, 2, 4, 8 or full row; burst terminate stops early
// - auto precharge closes the row by itself when the burst ends
// - a new column command is accepted every cycle, any column, back to back
// - one bank can be precharged while another bank is being accessed
// - read data appears after a read latency of 1, 2 or 3 cycles
// - address bit ten: auto precharge on access, all banks on PRECHARGE
// - chip select high masks commands, running bursts and masks continue
// - mask high blocks write bytes, and floats read bytes two clocks later
module qbsdr_array #(
  parameter int ROWS_W = qbsdr_pkg::ROW_W,
  parameter int COLS_W = qbsdr_pkg::COL_W
) (
  input  wire logic                               sys_clk,
  input  wire logic                               reset,
  input  wire logic                               cs_n,
  input  wire logic                               ras_n,
  input  wire logic                               cas_n,
  input  wire logic                               we_n,
  input  wire logic [qbsdr_pkg::BANK_W-1:0]       bank_addr,
  input  wire logic [ROWS_W-1:0]                  addr,
  input  wire logic [qbsdr_pkg::MASK_W-1:0]       dqm,
  input  wire logic [qbsdr_pkg::DATA_W-1:0]       dq_in,
  input  wire logic [2:0]                         burst_length_setting,
  input  wire logic [1:0]                         read_latency_setting,
  input  wire logic                               automotive_temperature_option,
  output logic      [qbsdr_pkg::DATA_W-1:0]       dq_out,
  output logic      [qbsdr_pkg::MASK_W-1:0]       dq_oe
);
  localparam int NBANK = 1 << qbsdr_pkg::BANK_W;
  localparam int DEPTH = NBANK << (ROWS_W + COLS_W);
  localparam int IDX_W = qbsdr_pkg::BANK_W + ROWS_W + COLS_W;
  localparam int LAT   = qbsdr_pkg::LAT_MAX;

  function automatic logic [qbsdr_pkg::LEN_W-1:0] len_of(input logic [2:0] code);
    case (code)
      qbsdr_pkg::BL_1:    len_of = 9'h001;
      qbsdr_pkg::BL_2:    len_of = 9'h002;
      qbsdr_pkg::BL_4:    len_of = 9'h004;
      qbsdr_pkg::BL_8:    len_of = 9'h008;
      default:            len_of = 9'h100;
    endcase
  endfunction

  // sequential order wraps inside the aligned block of the burst length
  function automatic logic [COLS_W-1:0] burst_col(input logic [COLS_W-1:0]          start,
                                                  input logic [qbsdr_pkg::LEN_W-1:0] idx,
                                                  input logic [qbsdr_pkg::LEN_W-1:0] len);
    logic [COLS_W-1:0] m;
    logic [COLS_W-1:0] s;
    m = COLS_W'(len - 9'h001);
    s = start + COLS_W'(idx);
    burst_col = (start & ~m) | (s & m);
  endfunction

  logic [qbsdr_pkg::DATA_W-1:0] mem [DEPTH];
  logic [NBANK-1:0]             open_r;
  logic [ROWS_W-1:0]            row_r [NBANK];
  logic                         bst_act_r;
  logic                         bst_wr_r;
  logic                         bst_ap_r;
  logic                         bst_page_r;
  logic [qbsdr_pkg::BANK_W-1:0] bst_bank_r;
  logic [COLS_W-1:0]            bst_col_r;
  logic [qbsdr_pkg::LEN_W-1:0]  bst_cnt_r;
  logic [qbsdr_pkg::LEN_W-1:0]  bst_len_r;
  logic [qbsdr_pkg::DATA_W-1:0] pipe_d_r [LAT];
  logic [LAT-1:0]               pipe_v_r;
  logic [qbsdr_pkg::MASK_W-1:0] dqm_d_r [qbsdr_pkg::DQM_DELAY];
  logic [qbsdr_pkg::MASK_W-1:0] dq_oe_r;

  // chip select high decodes as nop, so only the running burst moves
  wire qbsdr_pkg::qbsdr_cmd_e cmd = qbsdr_pkg::qbsdr_cmd_e'({cs_n, ras_n, cas_n, we_n});
  wire cmd_act = (cmd == qbsdr_pkg::QBSDR_CMD_ACT);
  wire cmd_pre = (cmd == qbsdr_pkg::QBSDR_CMD_PRE);
  wire cmd_bst = (cmd == qbsdr_pkg::QBSDR_CMD_BST);
  wire cmd_rw  = ((cmd == qbsdr_pkg::QBSDR_CMD_RD) || (cmd == qbsdr_pkg::QBSDR_CMD_WR))
                 && open_r[bank_addr];
  wire cmd_wr  = (cmd == qbsdr_pkg::QBSDR_CMD_WR);

  // a fresh column command pre-empts the running burst in the same cycle
  wire                         beat_go   = cmd_rw || (bst_act_r && !cmd_bst);
  wire                         beat_wr   = cmd_rw ? cmd_wr : bst_wr_r;
  wire [qbsdr_pkg::BANK_W-1:0] beat_bank = cmd_rw ? bank_addr : bst_bank_r;
  wire [qbsdr_pkg::LEN_W-1:0]  beat_len  = cmd_rw ? len_of(burst_length_setting) : bst_len_r;
  wire [qbsdr_pkg::LEN_W-1:0]  beat_idx  = cmd_rw ? 9'h000 : bst_cnt_r;
  wire                         beat_page = cmd_rw ? (burst_length_setting == qbsdr_pkg::BL_PAGE)
                                                  : bst_page_r;
  wire                         beat_ap   = cmd_rw ? addr[qbsdr_pkg::AP_BIT] : bst_ap_r;
  wire [COLS_W-1:0]            beat_col  = cmd_rw ? addr[COLS_W-1:0]
                                                  : burst_col(bst_col_r, bst_cnt_r, bst_len_r);
  wire [IDX_W-1:0]             beat_addr = {beat_bank, row_r[beat_bank], beat_col};
  // full-row bursts wrap until terminated
  wire beat_last  = !beat_page && ((beat_idx + 9'h001) == beat_len);
  wire rd_beat    = beat_go && !beat_wr;
  wire wr_beat    = beat_go && beat_wr;
  wire ap_close   = bst_act_r && bst_ap_r && (cmd_rw || cmd_bst);    // interrupted ap burst
  wire [1:0] lat_idx = (read_latency_setting == 2'h0) ? 2'h0 : read_latency_setting - 2'h1;

  // write with byte masks; write data is taken on the command edge
  always_ff @(posedge sys_clk) begin
    if (wr_beat) begin
      for (int b = 0; b < qbsdr_pkg::MASK_W; b++) begin
        if (!dqm[b]) begin
          mem[beat_addr][8*b +: 8] <= dq_in[8*b +: 8];
        end
      end
    end
  end

  // bank state: ACTIVE and PRECHARGE act on any bank, auto precharge closes the burst bank
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      open_r <= '0;
    end else begin
      if (ap_close) begin
        open_r[bst_bank_r] <= 1'b0;
      end
      if (beat_go && beat_last && beat_ap) begin
        open_r[beat_bank] <= 1'b0;
      end
      if (cmd_pre) begin
        if (addr[qbsdr_pkg::AP_BIT]) begin
          open_r <= '0;
        end else begin
          open_r[bank_addr] <= 1'b0;
        end
      end
      if (cmd_act) begin
        open_r[bank_addr] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (cmd_act) begin
      row_r[bank_addr] <= addr;
    end
  end

  // burst engine
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bst_act_r  <= 1'b0;
      bst_wr_r   <= 1'b0;
      bst_ap_r   <= 1'b0;
      bst_page_r <= 1'b0;
      bst_bank_r <= '0;
      bst_col_r  <= '0;
      bst_cnt_r  <= '0;
      bst_len_r  <= 9'h001;
    end else begin
      bst_act_r <= beat_go && !beat_last;
      bst_cnt_r <= beat_idx + 9'h001;
      if (cmd_rw) begin
        bst_wr_r   <= cmd_wr;
        bst_ap_r   <= addr[qbsdr_pkg::AP_BIT];
        bst_page_r <= beat_page;
        bst_bank_r <= bank_addr;
        bst_col_r  <= addr[COLS_W-1:0];
        bst_len_r  <= beat_len;
      end
    end
  end

  // read pipeline: entry at latency slot, stage 0 drives the pins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pipe_v_r <= '0;
    end else begin
      // the top slot has no stage above it, so it only takes new entries
      for (int i = 0; i < LAT - 1; i++) begin
        pipe_v_r[i] <= (rd_beat && (i == int'(lat_idx))) || pipe_v_r[i+1];
      end
      pipe_v_r[LAT-1] <= rd_beat && ((LAT - 1) == int'(lat_idx));
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < LAT - 1; i++) begin
      if (rd_beat && (i == int'(lat_idx))) begin
        pipe_d_r[i] <= mem[beat_addr];
      end else begin
        pipe_d_r[i] <= pipe_d_r[i+1];
      end
    end
    if (rd_beat && ((LAT - 1) == int'(lat_idx))) begin
      pipe_d_r[LAT-1] <= mem[beat_addr];
    end
  end

  // mask delay line; read bytes float two edges after the mask is sampled
  wire pipe0_v_nxt = (rd_beat && (lat_idx == 2'h0)) || pipe_v_r[1];
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dqm_d_r[0] <= '0;
      dqm_d_r[1] <= '0;
      dq_oe_r    <= '0;
    end else begin
      dqm_d_r[0] <= dqm;
      dqm_d_r[1] <= dqm_d_r[0];
      dq_oe_r    <= {qbsdr_pkg::MASK_W{pipe0_v_nxt}} & ~dqm_d_r[1];
    end
  end

  assign dq_out = pipe_d_r[0];
  assign dq_oe  = dq_oe_r;
endmodule

// *** hdl/qbsdr_pkg.sv ***
/*
  constants shared by the quad-bank sdram array model: command codes, burst codes,
  geometry and read-pipeline depth.
  assumes the controller and the array share sys_clk.
*/
package qbsdr_pkg;
  localparam int BANK_W     = 2;
  localparam int ROW_W      = 12;
  localparam int COL_W      = 8;
  localparam int DATA_W     = 32;
  localparam int MASK_W     = 4;
  localparam int LAT_MAX    = 3;
  localparam int DQM_DELAY  = 2;
  localparam int AP_BIT     = 10;
  localparam int LEN_W      = 9;

  // {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    QBSDR_CMD_LMR = 4'h0,
    QBSDR_CMD_REF = 4'h1,
    QBSDR_CMD_PRE = 4'h2,
    QBSDR_CMD_ACT = 4'h3,
    QBSDR_CMD_WR  = 4'h4,
    QBSDR_CMD_RD  = 4'h5,
    QBSDR_CMD_BST = 4'h6,
    QBSDR_CMD_NOP = 4'h7
  } qbsdr_cmd_e;

  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
endpackage

// *** sim/qbsdr_array_chk.sv ***
/* checker on the array pins: read latency, byte masks, burst cut-off, reset.
   assumes one clock domain; bound to every qbsdr_array. */
`timescale 1ns/10ps
module qbsdr_array_chk (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [3:0]  dqm,
  input wire logic [1:0]  read_latency_setting,
  input wire logic [3:0]  dq_oe
);
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  wire       rd_c = cmd == qbsdr_pkg::QBSDR_CMD_RD;
  wire       cl1 = read_latency_setting < 2'h2;
  wire       oe_any = |dq_oe;
  wire       all_m = &dqm;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  rst_idle_a: assert property ($fell(reset) |-> dq_oe == 4'h0)
    else $error("pins driven after reset");
  mask_float_a: assert property ((dq_oe & $past(dqm, 3)) == 4'h0)
    else $error("masked byte driven");
  oe_full_a: assert property (oe_any |-> (dq_oe | $past(dqm, 3)) == 4'hf)
    else $error("unmasked byte idle");
  // backward checks only: a read to a closed bank rightly stays silent
  cl1_start_a: assert property ($rose(oe_any) && cl1 && !$past(all_m, 4) |-> $past(rd_c))
    else $error("first beat not one cycle after read");
  cl2_start_a: assert property ($rose(oe_any) && read_latency_setting == 2'h2
    && !$past(all_m, 4) |-> $past(rd_c, 2)) else $error("first beat not two after read");
  cl3_start_a: assert property ($rose(oe_any) && read_latency_setting == 2'h3
    && !$past(all_m, 4) |-> $past(rd_c, 3)) else $error("first beat not three after read");
  wr_cut_a: assert property (cl1 && cmd == qbsdr_pkg::QBSDR_CMD_WR |=> !oe_any)
    else $error("read beat after write");
  bst_cut_a: assert property (cl1 && cmd == qbsdr_pkg::QBSDR_CMD_BST |=> !oe_any)
    else $error("read beat after terminate");
  cover property (rd_c && cl1);
  cover property (cmd == qbsdr_pkg::QBSDR_CMD_BST);
  cover property ($rose(oe_any) && read_latency_setting == 2'h3);
endmodule
bind qbsdr_array qbsdr_array_chk chk_u (.*);

// *** sim/qbsdr_ctrl.sv ***
/* controller model: one command per cycle, write data on the shared data wire.
   assumes the bench calls op from one process only. */
`timescale 1ns/10ps
module qbsdr_ctrl (
  input  wire logic        sys_clk,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [1:0]       bank_addr,
  output logic [11:0]      addr,
  output logic [3:0]       dqm,
  output logic [31:0]      dq_in,
  input  wire logic [31:0] dq_out,
  input  wire logic [3:0]  dq_oe
);
  logic [31:0] wd;
  logic        wen;
  wire  [31:0] m = {{8{dq_oe[3]}}, {8{dq_oe[2]}}, {8{dq_oe[1]}}, {8{dq_oe[0]}}};
  // a released wire shows the inverse word, so stale data never passes
  assign dq_in = (dq_out & m) | ((wen ? wd : ~wd) & ~m);
  // runs stay far inside the 16 ms window; self refresh never issued
  initial {cs_n, ras_n, cas_n, we_n, bank_addr, addr, dqm, wd, wen} = {4'hf, 51'h0};
  // pins change on the falling edge, clear of the sampling edge
  task automatic op(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                    input logic [31:0] d, input logic w, input logic [3:0] k);
    @(negedge sys_clk);
    {cs_n, ras_n, cas_n, we_n, bank_addr, addr, wd, wen, dqm} = {c, b, a, d, w, k};
  endtask
endmodule

// *** sim/qbsdr_array_tb.sv ***
/* bench: sweeps latency and burst length, writes a burst and reads it back.
   assumes qbsdr_ctrl drives the pins and the checker is bound to the array. */
`timescale 1ns/10ps
module qbsdr_array_tb;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [2:0]  burst_length_setting = 3'h0;
  logic [1:0]  read_latency_setting = 2'h1;
  logic        automotive_temperature_option = 1'b0;
  wire         cs_n, ras_n, cas_n, we_n;
  wire  [1:0]  bank_addr;
  wire  [11:0] addr;
  wire  [3:0]  dqm, dq_oe;
  wire  [31:0] dq_in, dq_out;
  wire  [31:0] m = {{8{dq_oe[3]}}, {8{dq_oe[2]}}, {8{dq_oe[1]}}, {8{dq_oe[0]}}};
  logic [31:0] seed = 32'hff9c3245;
  logic [31:0] expq[$];
  int          miscompares = 0;
  int          n_compared = 0;
  qbsdr_ctrl  ctrl_u (.*);
  qbsdr_array dut_u (.*);
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial forever #5 sys_clk = ~sys_clk;
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    give_verdict();
  end
  // masked bytes float, so only driven bytes are compared
  always @(negedge sys_clk) begin
    if (!reset && dq_oe !== 4'h0) begin
      if (expq.size() == 0) chk({28'h0, dq_oe}, 0);
      else chk(dq_out & m, expq.pop_front() & m);
    end
  end
  initial begin
    logic [31:0] d[8];
    logic [1:0]  b;
    logic [7:0]  c;
    int          n, r;
    repeat (8) @(negedge sys_clk);
    reset = 1'b0;
    for (int l = 1; l < 4; l++) begin
      for (int k = 0; k < 5; k++) begin
        read_latency_setting = 2'(l);
        burst_length_setting = (k < 4) ? 3'(k) : qbsdr_pkg::BL_PAGE;
        automotive_temperature_option = ^rnd();
        n = (k < 4) ? 1 << k : 256;
        r = (k < 4) ? n : 7;
        b = 2'(k);
        c = 8'(rnd()) & 8'hf8;
        ctrl_u.op(qbsdr_pkg::QBSDR_CMD_ACT, b, 12'(rnd()), 0, 0, 0);
        ctrl_u.op(qbsdr_pkg::QBSDR_CMD_NOP, b, 0, 0, 0, 0);
        for (int j = 0; j < r + k / 4; j++) begin
          d[j] = rnd();
          ctrl_u.op(j ? {1'b1, 3'(rnd())} : qbsdr_pkg::QBSDR_CMD_WR, b, {4'h0, c}, d[j], 1, 0);
        end
        if (k == 4) ctrl_u.op(qbsdr_pkg::QBSDR_CMD_BST, b, 0, 0, 0, 0);
        for (int i = 0; i < r; i++) expq.push_back(d[(i + (n > 1)) & (n - 1)]);
        ctrl_u.op(qbsdr_pkg::QBSDR_CMD_RD, b, 12'h400 | 12'(c + (n > 1)), 0, 0, 0);
        for (int i = 0; i < r + 3; i++) begin
          if (i == 0) ctrl_u.op(qbsdr_pkg::QBSDR_CMD_PRE, b + 2'h1, 0, 0, 0, 4'(rnd()) & 4'h7);
          else if (k == 4 && i == r - 1) ctrl_u.op(qbsdr_pkg::QBSDR_CMD_BST, b, 0, 0, 0, 0);
          else ctrl_u.op({1'b1, 3'(rnd())}, b, 12'(rnd()), 0, 0, 4'(rnd()) & 4'h7);
        end
        // bank was closed by its own burst, so this read must stay silent
        ctrl_u.op(qbsdr_pkg::QBSDR_CMD_RD, b, {4'h0, c}, 0, 0, 0);
        repeat (4) ctrl_u.op(qbsdr_pkg::QBSDR_CMD_NOP, b, 0, 0, 0, 0);
        $display("test latency %0d burst %0d done", l, n);
      end
    end
    // two banks open at once: closing one leaves the other readable, all-banks closes both
    burst_length_setting = qbsdr_pkg::BL_1;
    read_latency_setting = 2'h2;
    d[0] = rnd();
    ctrl_u.op(qbsdr_pkg::QBSDR_CMD_ACT, 2'h1, 12'(rnd()), 0, 0, 0);
    ctrl_u.op(qbsdr_pkg::QBSDR_CMD_ACT, 2'h2, 12'(rnd()), 0, 0, 0);
    ctrl_u.op(qbsdr_pkg::QBSDR_CMD_NOP, 2'h0, 0, 0, 0, 0);
    ctrl_u.op(qbsdr_pkg::QBSDR_CMD_WR, 2'h1, 12'h010, d[0], 1, 0);
    ctrl_u.op(qbsdr_pkg::QBSDR_CMD_WR, 2'h2, 12'h010, ~d[0], 1, 0);
    expq.push_back(d[0]);
    expq.push_back(d[0]);
    ctrl_u.op(qbsdr_pkg::QBSDR_CMD_RD, 2'h1, 12'h010, 0, 0, 0);
    ctrl_u.op(qbsdr_pkg::QBSDR_CMD_PRE, 2'h2, 12'h000, 0, 0, 0);
    ctrl_u.op(qbsdr_pkg::QBSDR_CMD_RD, 2'h1, 12'h010, 0, 0, 0);
    ctrl_u.op(qbsdr_pkg::QBSDR_CMD_RD, 2'h2, 12'h010, 0, 0, 0);
    ctrl_u.op(qbsdr_pkg::QBSDR_CMD_PRE, 2'h2, 12'h400, 0, 0, 0);
    ctrl_u.op(qbsdr_pkg::QBSDR_CMD_RD, 2'h1, 12'h010, 0, 0, 0);
    repeat (4) ctrl_u.op(qbsdr_pkg::QBSDR_CMD_NOP, 2'h0, 0, 0, 0, 0);
    $display("test bank overlap done");
    chk(32'(expq.size()), 0);
    give_verdict();
  end
endmodule
